// ===== design/fsps_sequencer.sv
// Flash self-program sequencer top with APB registers
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module fsps_sequencer
   import fsps_pkg::*;
#(
   parameter int ERASE_CYCLES = ERASE_CYC, // Row erase length
   parameter int PROG_CYCLES  = PROG_CYC   // Block program length
)(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [APB_AW-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic                   core_stall,
   output logic                   flash_erase_en,
   output logic                   flash_prog_en,
   output logic [ROW_W-1:0]       flash_row,
   output logic                   flash_cfg_sel,
   input  wire logic [IDX_W-1:0]  flash_word_idx,
   output logic [WORD_W-1:0]      flash_word_data
);

   // Refuse lengths the counter cannot serve
   if (ERASE_CYCLES < 1 || PROG_CYCLES < 1) begin : g_chk
      $error("fsps_sequencer: cycle counts must be >= 1");
   end

   // Register offset match, shared by read and write
   function automatic logic hit(
      input logic [APB_AW-1:0] a,
      input logic [4:0]        off
   );
      return a == off;
   endfunction

   // Software visible registers
   logic [7:0]  addr_lo_reg;   // flash_addr_low
   logic [6:0]  addr_hi_reg;   // flash_addr_high
   logic [7:0]  data_lo_reg;   // flash_data_low
   logic [5:0]  data_hi_reg;   // flash_data_high
   logic [7:0]  ctl_reg;       // nvm_control
   logic [31:0] prdata_reg;    // Read data for access phase

   // Sequencer state
   fsps_state_t state_reg;     // Current phase
   logic [31:0] cnt_reg;       // Phase cycle counter
   logic        op_erase_reg;  // Pending op is a row erase
   logic [ROW_W-1:0] row_reg;  // Target row or block
   logic        cfg_reg;       // Config space target

   // Bus decode and strobes
   logic        mapped;        // Address names a register
   logic        busy;          // Action in flight
   logic        wr_take;       // Write accepted this edge
   logic        ctl_hit;       // Write targets control
   logic        key_hit;       // Write targets key
   logic        go;            // Key plus start accepted
   logic        go_erase;      // Accepted start is an erase
   logic        go_load;       // Accepted start loads latch
   logic        go_prog;       // Accepted start programs
   logic        setup_done;    // Setup phase finished
   logic        erase_done;    // Erase phase finished
   logic        prog_done;     // Program phase finished
   logic [31:0] rd_mux;        // Read value before capture

   fsps_latch_if lat ();       // Write latch group

   // Address decode
   always_comb begin
      mapped = hit(paddr, OFF_ADDR_LO) ||
               hit(paddr, OFF_ADDR_HI) ||
               hit(paddr, OFF_DATA_LO) ||
               hit(paddr, OFF_DATA_HI) ||
               hit(paddr, OFF_CONTROL) ||
               hit(paddr, OFF_KEY);
   end

   // Zero wait states; an unmapped address errors
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata  = prdata_reg;

   // Writes during an action are dropped, setup cycles included
   assign busy    = state_reg != ST_IDLE;
   assign wr_take = psel && penable && pwrite && mapped && !busy;
   assign ctl_hit = hit(paddr, OFF_CONTROL);
   assign key_hit = hit(paddr, OFF_KEY);

   // Key sequencing lives in its own tracker
   fsps_unlock_key u_key (
      .clk     (pclk),
      .rst_n   (presetn),
      .wr_take (wr_take),
      .key_hit (key_hit),
      .ctl_hit (ctl_hit),
      .wdata   (pwdata[7:0]),
      .go      (go)
   );

   // Only program memory starts are served here
   always_comb begin
      go_erase = go && pwdata[CTL_PGM] && pwdata[CTL_ERASE];
      go_load  = go && pwdata[CTL_PGM] && !pwdata[CTL_ERASE];
      go_prog  = go_load && !pwdata[CTL_LOAD_LATCHES_ONLY];
   end

   // Phase ends
   always_comb begin
      setup_done = state_reg == ST_SETUP && cnt_reg == 32'h0;
      erase_done = state_reg == ST_ERASE && cnt_reg == 32'h0;
      prog_done  = state_reg == ST_PROG  && cnt_reg == 32'h0;
   end

   // Address pair
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_lo_reg <= 8'h00;
         addr_hi_reg <= 7'h00;
      end else if (wr_take) begin
         if (hit(paddr, OFF_ADDR_LO)) begin
            addr_lo_reg <= pwdata[7:0];
         end
         if (hit(paddr, OFF_ADDR_HI)) begin
            addr_hi_reg <= pwdata[6:0];
         end
      end
   end

   // Data pair
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_lo_reg <= 8'h00;
         data_hi_reg <= 6'h00;
      end else if (wr_take) begin
         if (hit(paddr, OFF_DATA_LO)) begin
            data_lo_reg <= pwdata[7:0];
         end
         if (hit(paddr, OFF_DATA_HI)) begin
            data_hi_reg <= pwdata[5:0];
         end
      end
   end

   // Control register: software bits, hardware clears
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_reg <= CTL_RESET;
      end else if (wr_take && ctl_hit) begin
         // Start is only stored when the key accepted it
         ctl_reg <= pwdata[7:0] & CTL_WMASK;
         ctl_reg[CTL_START] <= go_erase || go_load;
      end else if (erase_done) begin
         // Erase bit is the firmware's completion flag
         ctl_reg[CTL_ERASE] <= 1'b0;
         ctl_reg[CTL_START] <= 1'b0;
      end else if (prog_done) begin
         ctl_reg[CTL_START] <= 1'b0;
      end else if (!busy && ctl_reg[CTL_START]) begin
         // A latch load finishes in the cycle it is taken
         ctl_reg[CTL_START] <= 1'b0;
      end
   end

   // Capture target at the start so later writes cannot move it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         row_reg <= '0;
         cfg_reg <= 1'b0;
      end else if (go_erase || go_prog) begin
         // Low five address bits pick a word, not a row
         row_reg <= {addr_hi_reg, addr_lo_reg[7:IDX_W]};
         cfg_reg <= pwdata[CTL_CONFIG_SPACE_SELECT];
      end
   end

   // Remember which action waits behind the setup cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_erase_reg <= 1'b0;
      end else if (go_erase || go_prog) begin
         op_erase_reg <= go_erase;
      end
   end

   // Phase sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= 32'h0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (go_erase || go_prog) begin
                  // Core runs its two fill instructions here
                  state_reg <= ST_SETUP;
                  cnt_reg   <= 32'(SETUP_CYC - 1);
               end
            end
            ST_SETUP: begin
               if (setup_done && op_erase_reg) begin
                  state_reg <= ST_ERASE;
                  cnt_reg   <= 32'(ERASE_CYCLES - 1);
               end else if (setup_done) begin
                  state_reg <= ST_PROG;
                  cnt_reg   <= 32'(PROG_CYCLES - 1);
               end else begin
                  cnt_reg <= cnt_reg - 32'h1;
               end
            end
            ST_ERASE: begin
               if (erase_done) begin
                  state_reg <= ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 32'h1;
               end
            end
            ST_PROG: begin
               if (prog_done) begin
                  state_reg <= ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 32'h1;
               end
            end
         endcase
      end
   end

   // Latch loads: the final word goes in before programming
   always_comb begin
      lat.wr_en   = go_load;
      // Index wraps inside the block, never into the next
      lat.wr_idx  = addr_lo_reg[IDX_W-1:0];
      lat.wr_data = {data_hi_reg, data_lo_reg};
      lat.clear   = prog_done;
      lat.rd_idx  = flash_word_idx;
   end

   fsps_latch_block u_latch (
      .clk   (pclk),
      .rst_n (presetn),
      .lat   (lat)
   );

   // Flash array controls; no erase is folded into a program
   always_comb begin
      flash_erase_en  = state_reg == ST_ERASE;
      flash_prog_en   = state_reg == ST_PROG;
      flash_row       = row_reg;
      flash_cfg_sel   = cfg_reg;
      // Whole block is streamed, loaded or not
      flash_word_data = lat.rd_data;
   end

   // Stall holds the core only after setup, clocks keep running
   assign core_stall = state_reg == ST_ERASE ||
                       state_reg == ST_PROG;

   // Read mux; the key register reads as zero
   always_comb begin
      rd_mux = 32'h0;
      if (hit(paddr, OFF_ADDR_LO)) begin
         rd_mux[7:0] = addr_lo_reg;
      end else if (hit(paddr, OFF_ADDR_HI)) begin
         rd_mux[6:0] = addr_hi_reg;
      end else if (hit(paddr, OFF_DATA_LO)) begin
         rd_mux[7:0] = data_lo_reg;
      end else if (hit(paddr, OFF_DATA_HI)) begin
         rd_mux[5:0] = data_hi_reg;
      end else if (ctl_hit) begin
         rd_mux[7:0] = ctl_reg;
      end
   end

   // Read data captured in the setup phase, stable in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         prdata_reg <= rd_mux;
      end
   end

endmodule // fsps_sequencer
`default_nettype wire

// ===== include/fsps_pkg.sv
// Constants and types for the flash self-program sequencer
package fsps_pkg;
   // Register byte offsets on the APB bus
   localparam int          APB_AW       = 5;
   localparam logic [4:0]  OFF_ADDR_LO  = 5'h00;
   localparam logic [4:0]  OFF_ADDR_HI  = 5'h04;
   localparam logic [4:0]  OFF_DATA_LO  = 5'h08;
   localparam logic [4:0]  OFF_DATA_HI  = 5'h0C;
   localparam logic [4:0]  OFF_CONTROL  = 5'h10;
   localparam logic [4:0]  OFF_KEY      = 5'h14;
   // Field positions in nvm_control
   localparam int          CTL_START    = 0;
   localparam int          CTL_WRITE_ENABLE_BIT     = 1;
   localparam int          CTL_ERASE    = 2;
   localparam int          CTL_LOAD_LATCHES_ONLY     = 5;
   localparam int          CTL_CONFIG_SPACE_SELECT     = 6;
   localparam int          CTL_PGM      = 7;
   localparam logic [7:0]  CTL_RESET    = 8'h00;
   localparam logic [7:0]  CTL_WMASK    = 8'hE6;
   // Unlock key values
   localparam logic [7:0]  KEY_FIRST    = 8'h55;
   localparam logic [7:0]  KEY_SECOND   = 8'hAA;
   // Flash geometry
   localparam int          WORD_W       = 14;
   localparam int          LATCH_N      = 32;
   localparam int          IDX_W        = 5;
   localparam int          ROW_W        = 10;
   localparam logic [13:0] LATCH_BLANK  = 14'h3FFF;
   // Timing
   localparam int          CLK_MHZ      = 100;
   localparam int          SETUP_CYC    = 2;
   localparam int          ERASE_US     = 2000;
   localparam int          ERASE_CYC    = ERASE_US * CLK_MHZ;
   localparam int          PROG_US      = 2000;
   localparam int          PROG_CYC     = PROG_US * CLK_MHZ;
   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SETUP = 2'b01,
      ST_ERASE = 2'b10,
      ST_PROG  = 2'b11
   } fsps_state_t;
   // Unlock key progress
   typedef enum logic [1:0] {
      KEY_IDLE  = 2'b00,
      KEY_HALF  = 2'b01,
      KEY_ARMED = 2'b10
   } fsps_key_t;
endpackage

// ===== include/fsps_latch_if.sv
// Write latch access group between sequencer and latch block
`timescale 1ns/10ps
`default_nettype none
interface fsps_latch_if;
   import fsps_pkg::*;
   logic              wr_en;   // Load one latch
   logic [IDX_W-1:0]  wr_idx;  // Latch to load
   logic [WORD_W-1:0] wr_data; // Word to load
   logic              clear;   // Return all to blank
   logic [IDX_W-1:0]  rd_idx;  // Latch read select
   logic [WORD_W-1:0] rd_data; // Selected latch
   modport owner (input wr_en, wr_idx, wr_data, clear, rd_idx,
                  output rd_data);
   modport user  (output wr_en, wr_idx, wr_data, clear, rd_idx,
                  input rd_data);
endinterface
`default_nettype wire

// ===== design/fsps_latch_block.sv
// Block of flash write latches
`timescale 1ns/10ps
`default_nettype none
module fsps_latch_block
   import fsps_pkg::*;
(
   input wire logic    clk,
   input wire logic    rst_n,
   fsps_latch_if.owner lat
);
   // Latch storage, flip-flops indexed by word
   logic [WORD_W-1:0] word_reg [LATCH_N];

   // Load one word, or clear all after programming
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < LATCH_N; i++) begin
            word_reg[i] <= LATCH_BLANK;
         end
      end else if (lat.clear) begin
         for (int i = 0; i < LATCH_N; i++) begin
            word_reg[i] <= LATCH_BLANK;
         end
      end else if (lat.wr_en) begin
         word_reg[lat.wr_idx] <= lat.wr_data;
      end
   end

   // Read port toward the flash array
   assign lat.rd_data = word_reg[lat.rd_idx];
endmodule // fsps_latch_block
`default_nettype wire

// ===== design/fsps_unlock_key.sv
// Unlock key tracker for flash actions
`timescale 1ns/10ps
`default_nettype none
module fsps_unlock_key
   import fsps_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       wr_take,
   input  wire logic       key_hit,
   input  wire logic       ctl_hit,
   input  wire logic [7:0] wdata,
   output logic            go
);
   fsps_key_t key_reg; // Key progress

   // Any write out of order drops the key
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         key_reg <= KEY_IDLE;
      end else if (wr_take) begin
         if (key_hit && wdata == KEY_FIRST) begin
            key_reg <= KEY_HALF;
         end else if (key_hit && wdata == KEY_SECOND &&
                      key_reg == KEY_HALF) begin
            key_reg <= KEY_ARMED;
         end else begin
            key_reg <= KEY_IDLE;
         end
      end
   end

   // Start honoured straight after the key, with enable set
   assign go = wr_take && ctl_hit && key_reg == KEY_ARMED &&
               wdata[CTL_START] && wdata[CTL_WRITE_ENABLE_BIT];
endmodule // fsps_unlock_key
`default_nettype wire

// ===== dv/fsps_sequencer_props.sv
// Port-level assertions for the flash self-program sequencer
`timescale 1ns/10ps
`default_nettype none
module fsps_sequencer_props
   import fsps_pkg::*;
#(
   parameter int ERASE_CYCLES = 20, // Erase phase length
   parameter int PROG_CYCLES  = 20  // Program phase length
)(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              core_stall,
   input wire logic              flash_erase_en,
   input wire logic              flash_prog_en,
   input wire logic [ROW_W-1:0]  flash_row,
   input wire logic [WORD_W-1:0] flash_word_data
);
   logic [31:0] run_cnt; // Cycles spent in the current stall
   logic        ctl_go;  // Control write carrying the start bit
   logic        mapped;  // Access hits one of the six words
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign ctl_go = psel && penable && pwrite && paddr == OFF_CONTROL
                   && pwdata[CTL_START];
   assign mapped = paddr[1:0] == 2'b00 && paddr <= OFF_KEY;
   // Stall length counter, cleared whenever the core runs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         run_cnt <= '0;
      else if (core_stall)
         run_cnt <= run_cnt + 32'h1;
      else
         run_cnt <= '0;
   end
   stall_cause_a: assert property (
      core_stall == (flash_erase_en || flash_prog_en))
      else $error("stall does not match a flash phase");
   one_action_a: assert property (
      !(flash_erase_en && flash_prog_en))
      else $error("erase and program active together");
   setup_gap_a: assert property (
      $rose(core_stall) |-> $past(ctl_go, 3))
      else $error("stall did not follow start by two setup cycles");
   erase_len_a: assert property (
      $fell(flash_erase_en) |-> run_cnt == ERASE_CYCLES)
      else $error("erase phase length wrong");
   prog_len_a: assert property (
      $fell(flash_prog_en) |-> run_cnt == PROG_CYCLES)
      else $error("program phase length wrong");
   row_hold_a: assert property (
      core_stall && $past(core_stall) |-> $stable(flash_row))
      else $error("row moved during a flash phase");
   latch_blank_a: assert property (
      $fell(flash_prog_en) |-> flash_word_data == LATCH_BLANK)
      else $error("latch not blank after programming");
   unmapped_err_a: assert property (
      psel && penable && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   zero_wait_a: assert property (
      psel && penable |-> pready)
      else $error("access phase not answered");
   // Main scenarios reached
   erase_seen_c: cover property ($rose(flash_erase_en));
   prog_seen_c:  cover property ($rose(flash_prog_en));
   err_seen_c:   cover property (psel && penable && pslverr);
endmodule // fsps_sequencer_props
`default_nettype wire

// ===== dv/fsps_flash_model.sv
// Flash array model for one row, on the far side of the sequencer
`timescale 1ns/10ps
`default_nettype none
module fsps_flash_model
   import fsps_pkg::*;
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              flash_erase_en,
   input  wire logic              flash_prog_en,
   input  wire logic [ROW_W-1:0]  flash_row,
   input  wire logic [WORD_W-1:0] flash_word_data,
   output logic [IDX_W-1:0]       flash_word_idx
);
   logic [WORD_W-1:0] img [LATCH_N]; // Contents of the row touched
   logic [ROW_W-1:0]  erased_row;    // Last row erased
   logic [ROW_W-1:0]  prog_row;      // Last row programmed
   // Index runs free so a stale word can never pass unnoticed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_word_idx <= '0;
         erased_row     <= '0;
         prog_row       <= '0;
         for (int i = 0; i < LATCH_N; i++)
            img[i] <= LATCH_BLANK;
      end else begin
         flash_word_idx <= flash_word_idx + 5'h1;
         // Whole row wiped at once
         if (flash_erase_en) begin
            erased_row <= flash_row;
            for (int i = 0; i < LATCH_N; i++)
               img[i] <= LATCH_BLANK;
         end
         // Programming only clears bits, never erases
         if (flash_prog_en) begin
            prog_row            <= flash_row;
            img[flash_word_idx] <= img[flash_word_idx] & flash_word_data;
         end
      end
   end
endmodule // fsps_flash_model
`default_nettype wire

// ===== dv/tb_flash_self_program_sequencer.sv
// Self-checking bench for the flash self-program sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_flash_self_program_sequencer;
   import fsps_pkg::*;
   localparam int ERASE_CYCLES = 20; // Short erase for simulation
   localparam int PROG_CYCLES  = 40; // Long enough to sweep all latches
   logic              pclk, presetn, psel, penable, pwrite;
   logic              pready, pslverr, core_stall, flash_cfg_sel;
   logic              flash_erase_en, flash_prog_en, err_seen;
   logic [APB_AW-1:0] paddr;
   logic [31:0]       pwdata, prdata, rd_val;
   logic [ROW_W-1:0]  flash_row;
   logic [IDX_W-1:0]  flash_word_idx;
   logic [WORD_W-1:0] flash_word_data;
   int                error_cnt, tests_run;
   fsps_sequencer #(
      .ERASE_CYCLES(ERASE_CYCLES),
      .PROG_CYCLES (PROG_CYCLES)
   ) fsps_sequencer_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .core_stall, .flash_erase_en,
      .flash_prog_en, .flash_row, .flash_cfg_sel, .flash_word_idx,
      .flash_word_data);
   fsps_flash_model fsps_flash_model_i (.pclk, .presetn, .flash_erase_en,
      .flash_prog_en, .flash_row, .flash_word_data, .flash_word_idx);
   // Free-running clock
   initial pclk = 1'b0;
   always #5 pclk = ~pclk;
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One APB transfer; idles one cycle after so psel is never reused
   task automatic apb(input logic wr, input logic [4:0] a,
                      input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a slave that never answers
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd_val   = prdata;
      err_seen = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Key pair then control write
   task automatic go(input logic [7:0] ctl);
      apb(1'b1, OFF_KEY, {24'h0, KEY_FIRST});
      apb(1'b1, OFF_KEY, {24'h0, KEY_SECOND});
      apb(1'b1, OFF_CONTROL, {24'h0, ctl});
   endtask
   // Poll until hardware drops the start bit, bounded only by the watchdog
   task automatic wait_done;
      // Unbounded here; a stuck start bit trips the watchdog
      do begin
         apb(1'b0, OFF_CONTROL, 32'h0);
      end while (rd_val[CTL_START] !== 1'b0);
   endtask
   // Reset contents and an unmapped word
   task automatic t_reset;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, 5'(i * 4), 32'h0);
         check(rd_val, 32'h0);
      end
      apb(1'b0, 5'h18, 32'h0);
      check({31'h0, err_seen}, 32'h1);
   endtask
   // Starts that must be ignored
   task automatic t_refuse;
      apb(1'b1, OFF_CONTROL, 32'h87);
      apb(1'b0, OFF_CONTROL, 32'h0);
      check(rd_val, 32'h86);
      apb(1'b1, OFF_KEY, 32'h55);
      apb(1'b1, OFF_ADDR_LO, 32'h40);
      apb(1'b1, OFF_KEY, 32'hAA);
      apb(1'b1, OFF_CONTROL, 32'h87);
      apb(1'b0, OFF_CONTROL, 32'h0);
      check(rd_val, 32'h86);
      go(8'h85);
      apb(1'b0, OFF_CONTROL, 32'h0);
      check(rd_val, 32'h84);
      check({31'h0, core_stall}, 32'h0);
   endtask
   // Row erase with a write lost during the stall
   task automatic t_erase;
      apb(1'b1, OFF_ADDR_HI, 32'h03);
      apb(1'b1, OFF_ADDR_LO, 32'h40);
      apb(1'b1, OFF_CONTROL, 32'h86);
      go(8'h87);
      apb(1'b1, OFF_ADDR_LO, 32'hFF);
      wait_done;
      check(rd_val, 32'h82);
      apb(1'b0, OFF_ADDR_LO, 32'h0);
      check(rd_val, 32'h40);
      check(32'(fsps_flash_model_i.erased_row), 32'h1A);
      check({31'h0, flash_cfg_sel}, 32'h0);
   endtask
   // Load one latch, then load the last and program the block
   task automatic t_prog;
      // Erase bit must stay clear, or the start becomes a row erase
      apb(1'b1, OFF_CONTROL, 32'hA2);
      apb(1'b1, OFF_ADDR_LO, 32'h43);
      apb(1'b1, OFF_DATA_HI, 32'h12);
      apb(1'b1, OFF_DATA_LO, 32'h34);
      go(8'hA3);
      wait_done;
      check(rd_val, 32'hA2);
      check(32'(fsps_flash_model_i.img[3]), 32'h3FFF);
      apb(1'b1, OFF_CONTROL, 32'h82);
      apb(1'b1, OFF_ADDR_LO, 32'h45);
      apb(1'b1, OFF_DATA_HI, 32'h0A);
      apb(1'b1, OFF_DATA_LO, 32'hBC);
      go(8'h83);
      wait_done;
      check(32'(fsps_flash_model_i.img[3]), 32'h1234);
      check(32'(fsps_flash_model_i.img[5]), 32'h0ABC);
      check(32'(fsps_flash_model_i.img[0]), 32'h3FFF);
      check(32'(fsps_flash_model_i.prog_row), 32'h1A);
   endtask
   // Counts then verdict
   task automatic give_verdict;
      $display("Mismatches %0d, comparisons %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Main sequence
   initial begin
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = '0;
      pwdata    = '0;
      presetn   = 1'b0;
      error_cnt = 0;
      tests_run = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_refuse;
      t_erase;
      t_prog;
      give_verdict;
   end
   // Watchdog, far beyond the few hundred cycles needed
   initial begin
      #100us;
      error_cnt++;
      give_verdict;
   end
endmodule // tb_flash_self_program_sequencer
bind fsps_sequencer fsps_sequencer_props #(
   .ERASE_CYCLES(ERASE_CYCLES),
   .PROG_CYCLES (PROG_CYCLES)
) fsps_sequencer_props_i (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .core_stall,
   .flash_erase_en, .flash_prog_en, .flash_row, .flash_word_data);
`default_nettype wire
